// [rtl/pwm_pkg.sv]
// Package with register map, field layout and carrier types of the PWM.
// Notes on behaviour
// - Four 8-bit channels, pairable into 16-bit.
// - Own period, duty, counter; four clock sources.
// - Duty settable from always inactive to active.
// - Each channel left or center aligned.
// - Enabled: new values wait for rollover.
// - Disabled: writes reach active latch at once.
// - Counter write clears it and loads latches.
// - Software can read every channel counter.
// - Enabled channel overrides the port pin, except paired ch1/ch3.
// - Upper pair: ch2 high, ch3 low byte.
// - Lower pair: ch0 high, ch1 low byte.
// - Clock A is P divided by power of two.
// - Clock B same encoding, channels 2 and 3.
// - Ch2/3 select clock B or scaled clock.
// - Ch0/1 select clock A or scaled clock.
// - Clock select may change while running.
// - Clock and polarity registers always accessible.
// - Polarity picks start level, flips at duty.
// - Enable forces pin output, gates channel clock; a pair uses only the ch0/ch2 enable.
// - Scaled clock is A or B over (scale+1) over two.
// - Center mode counts up and down.
package pwm_pkg;
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 12;
  localparam int PRESC_USED_W = 7;
  // Register indexes; the byte address is four times the index.
  localparam logic [7:0] IDX_CLK = 8'h40;
  localparam logic [7:0] IDX_POL = 8'h41;
  localparam logic [7:0] IDX_EN = 8'h42;
  localparam logic [7:0] IDX_PRESC = 8'h43;
  localparam logic [7:0] IDX_SCAL0 = 8'h44;
  localparam logic [7:0] IDX_SCNT0 = 8'h45;
  localparam logic [7:0] IDX_SCAL1 = 8'h46;
  localparam logic [7:0] IDX_SCNT1 = 8'h47;
  localparam logic [7:0] IDX_CNT0 = 8'h48;
  localparam logic [7:0] IDX_PER0 = 8'h4C;
  localparam logic [7:0] IDX_DUTY0 = 8'h50;
  localparam logic [7:0] IDX_ALIGN = 8'h54;
  // Field positions.
  localparam int CLK_PAIR_UPPER_BIT = 7;
  localparam int CLK_PAIR_LOWER_BIT = 6;
  localparam int CLK_PRESCALE_A_LSB = 3;
  localparam int CLK_PRESCALE_B_LSB = 0;
  localparam int POL_CLOCK_SEL_LSB = 4;
  localparam int POL_POLARITY_LSB = 0;
  // Reset values.
  localparam logic [7:0] RST_CLK = 8'h00;
  localparam logic [7:0] RST_POL = 8'h00;
  localparam logic [7:0] RST_PER = 8'hFF;
  localparam logic [7:0] RST_DUTY = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } pwm_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pwm_apb_rsp_t;

  typedef struct packed {
    logic [NUM_CH-1:0] o;
    logic [NUM_CH-1:0] oe;
  } pwm_pins_t;
endpackage : pwm_pkg

// [rtl/pwm_top.sv]
// Four-channel PWM with pairing, prescalers and APB register access.
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module pwm_top #(
  parameter int PRESC_BITS = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire pwm_pkg::pwm_apb_req_t apb_req,
  output var pwm_pkg::pwm_apb_rsp_t apb_rsp,
  input wire logic [pwm_pkg::NUM_CH-1:0] gpio_out,
  input wire logic [pwm_pkg::NUM_CH-1:0] port_direction_in,
  output var pwm_pkg::pwm_pins_t pins
);
  import pwm_pkg::*;

  if (PRESC_BITS < PRESC_USED_W) begin : g_chk
    $error("PRESC_BITS too small for divide by 128.");
  end

  // Pairing and the enable register layout assume exactly four channels.
  if (NUM_CH != 4) begin : g_chk_ch
    $error("Pairing and register layout need four channels.");
  end

  logic [7:0] clk_reg;
  logic [7:0] pol_reg;
  logic [NUM_CH-1:0] en_reg;
  logic [NUM_CH-1:0] align_reg;
  logic [PRESC_BITS-1:0] presc_reg;
  logic [7:0] scal_reg [2];
  logic [7:0] scnt_reg [2];
  logic half_reg [2];
  logic [7:0] cnt_reg [NUM_CH];
  logic [7:0] per_reg [NUM_CH];
  logic [7:0] duty_reg [NUM_CH];
  logic [7:0] per_act_reg [NUM_CH];
  logic [7:0] duty_act_reg [NUM_CH];
  logic down_reg [NUM_CH];
  logic [17:0] res [NUM_CH];
  logic [NUM_CH-1:0] step_en;
  logic [NUM_CH-1:0] wave;
  logic [1:0] pair;
  logic [1:0] tick_ab;
  logic [1:0] tick_s;
  logic [NUM_CH-1:0] tick_ch;
  logic [NUM_CH-1:0] pin_o_next;
  logic [NUM_CH-1:0] pin_oe_next;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic [7:0] idx;
  logic [7:0] wdat;
  logic setup;
  logic wr_acc;
  logic addr_ok;
  logic rd_hit;
  logic [7:0] rd_data;

  assign idx = apb_req.paddr[9:2];
  assign wdat = apb_req.pwdata[7:0];
  assign addr_ok = (apb_req.paddr[ADDR_W-1:10] == '0)
                   && (apb_req.paddr[1:0] == 2'h0);
  assign setup = apb_req.psel & ~apb_req.penable;
  assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite
                  & apb_rsp.pready & addr_ok;

  // Reads have no side effect, so the data is taken in the setup cycle.
  always_comb begin
    rd_hit = 1'b1;
    rd_data = 8'h00;
    case (idx)
      IDX_CLK: rd_data = clk_reg;
      IDX_POL: rd_data = pol_reg;
      IDX_EN: rd_data = {4'h0, en_reg};
      IDX_PRESC: rd_data = 8'(presc_reg[PRESC_USED_W-1:0]);
      IDX_SCAL0: rd_data = scal_reg[0];
      IDX_SCNT0: rd_data = scnt_reg[0];
      IDX_SCAL1: rd_data = scal_reg[1];
      IDX_SCNT1: rd_data = scnt_reg[1];
      IDX_ALIGN: rd_data = {4'h0, align_reg};
      default: rd_hit = 1'b0;
    endcase
    for (int c = 0; c < NUM_CH; c++) begin
      if (idx == 8'(IDX_CNT0 + c)) begin
        rd_data = cnt_reg[c];
        rd_hit = 1'b1;
      end
      if (idx == 8'(IDX_PER0 + c)) begin
        rd_data = per_reg[c];
        rd_hit = 1'b1;
      end
      if (idx == 8'(IDX_DUTY0 + c)) begin
        rd_data = duty_reg[c];
        rd_hit = 1'b1;
      end
    end
    if (!addr_ok) begin
      rd_hit = 1'b0;
      rd_data = 8'h00;
    end
  end

  // Zero wait states: pready rises in the access cycle itself.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_rsp <= '0;
    end else begin
      apb_rsp.pready <= setup;
      if (setup) begin
        apb_rsp.prdata <= {24'h000000, rd_data};
        apb_rsp.pslverr <= ~rd_hit;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_reg <= RST_CLK;
      pol_reg <= RST_POL;
      en_reg <= '0;
      align_reg <= '0;
      scal_reg[0] <= RST_ZERO;
      scal_reg[1] <= RST_ZERO;
    end else if (wr_acc) begin
      case (idx)
        IDX_CLK: clk_reg <= wdat;
        IDX_POL: pol_reg <= wdat;
        IDX_EN: en_reg <= wdat[NUM_CH-1:0];
        IDX_ALIGN: align_reg <= wdat[NUM_CH-1:0];
        IDX_SCAL0: scal_reg[0] <= wdat;
        IDX_SCAL1: scal_reg[1] <= wdat;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock sources
  // ----------------------------------------------------------------
  logic run;
  logic [2:0] code [2];

  // The prescaler stops while no channel is on, to save power.
  assign run = |en_reg;
  assign code[0] = clk_reg[CLK_PRESCALE_A_LSB +: 3];
  assign code[1] = clk_reg[CLK_PRESCALE_B_LSB +: 3];
  assign pair[0] = clk_reg[CLK_PAIR_LOWER_BIT];
  assign pair[1] = clk_reg[CLK_PAIR_UPPER_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_reg <= '0;
    end else if (run) begin
      presc_reg <= presc_reg + 1'b1;
    end
  end

  for (genvar s = 0; s < 2; s++) begin : g_scale
    // A tick when the low code bits of the prescaler are all ones.
    assign tick_ab[s] = run && ((presc_reg[PRESC_USED_W-1:0]
                        | (7'h7F << code[s])) == 7'h7F);
    assign tick_s[s] = tick_ab[s] && (scnt_reg[s] == 8'h00)
                       && half_reg[s];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        scnt_reg[s] <= RST_ZERO;
        half_reg[s] <= 1'b0;
      end else if (wr_acc && idx == ((s == 0) ? IDX_SCAL0 : IDX_SCAL1)) begin
        scnt_reg[s] <= wdat;
      end else if (tick_ab[s]) begin
        if (scnt_reg[s] == 8'h00) begin
          scnt_reg[s] <= scal_reg[s];
          half_reg[s] <= ~half_reg[s];
        end else begin
          scnt_reg[s] <= scnt_reg[s] - 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  // Result layout: {rollover, direction down, 16-bit count}.
  function automatic logic [17:0] step(input logic [15:0] cnt,
                                       input logic [15:0] per,
                                       input logic down,
                                       input logic center);
    logic [17:0] r;
    r = {2'b10, 16'h0000};
    if (!center) begin
      if (cnt < per) r = {2'b00, cnt + 16'h0001};
    end else if (down) begin
      if (cnt != 16'h0000) r = {2'b01, cnt - 16'h0001};
      else if (per != 16'h0000) r = {2'b10, 16'h0001};
    end else if (cnt < per) begin
      r = {2'b00, cnt + 16'h0001};
    end else if (per != 16'h0000) begin
      r = {2'b01, cnt - 16'h0001};
    end
    return r;
  endfunction : step

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    localparam int M = c ^ 1;
    localparam int H = c & 2;
    localparam bit IS_HI = (c % 2 == 0);
    logic con;
    logic [15:0] vc;
    logic [15:0] vp;
    logic [15:0] vd;
    logic lane_en;
    logic lane_roll;
    logic lane_step;
    logic clr;
    logic drive;

    assign con = pair[c/2];
    assign vc = (IS_HI && con) ? {cnt_reg[c], cnt_reg[M]}
                               : {8'h00, cnt_reg[c]};
    assign vp = (IS_HI && con) ? {per_act_reg[c], per_act_reg[M]}
                               : {8'h00, per_act_reg[c]};
    assign vd = (IS_HI && con) ? {duty_act_reg[c], duty_act_reg[M]}
                               : {8'h00, duty_act_reg[c]};
    // A pair runs on the low channel's clock selection.
    assign tick_ch[c] = pol_reg[POL_CLOCK_SEL_LSB + c] ? tick_s[c/2]
                        : tick_ab[c/2];
    assign res[c] = step(vc, vp, down_reg[c], align_reg[c]);
    assign step_en[c] = en_reg[c] && !(!IS_HI && con)
                        && ((IS_HI && con) ? tick_ch[M] : tick_ch[c]);
    assign lane_en = con ? en_reg[H] : en_reg[c];
    assign lane_step = con ? step_en[H] : step_en[c];
    assign lane_roll = con ? res[H][17] : res[c][17];
    assign clr = (wr_acc && idx == 8'(IDX_CNT0 + c))
                 || (con && wr_acc && idx == 8'(IDX_CNT0 + M));
    // Compare against the duty; polarity sets the starting level.
    assign wave[c] = pol_reg[POL_POLARITY_LSB + c] ? (vc < vd)
                     : (vc >= vd);
    assign drive = en_reg[c] && !(!IS_HI && con);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        per_reg[c] <= RST_PER;
        duty_reg[c] <= RST_DUTY;
      end else if (wr_acc) begin
        if (idx == 8'(IDX_PER0 + c)) per_reg[c] <= wdat;
        if (idx == 8'(IDX_DUTY0 + c)) duty_reg[c] <= wdat;
      end
    end

    // While off, the latches follow the buffers so no mixed waveform
    // is ever produced; while on, they load at a period boundary or on a counter write.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        per_act_reg[c] <= RST_PER;
        duty_act_reg[c] <= RST_DUTY;
      end else if (!lane_en || clr || (lane_step && lane_roll)) begin
        per_act_reg[c] <= per_reg[c];
        duty_act_reg[c] <= duty_reg[c];
      end
    end

    // Counters keep their value when disabled; software must clear them.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_reg[c] <= RST_ZERO;
        down_reg[c] <= 1'b0;
      end else if (clr) begin
        cnt_reg[c] <= RST_ZERO;
        down_reg[c] <= 1'b0;
      end else if (lane_step) begin
        if (IS_HI || !con) begin
          cnt_reg[c] <= (IS_HI && con) ? res[c][15:8] : res[c][7:0];
          down_reg[c] <= res[c][16];
        end else begin
          cnt_reg[c] <= res[H][7:0];
        end
      end
    end

    assign pin_o_next[c] = drive ? wave[c] : gpio_out[c];
    assign pin_oe_next[c] = drive | port_direction_in[c];
  end

  // ----------------------------------------------------------------
  // Pin stage
  // ----------------------------------------------------------------
  // One register for all pins, so each pin has a single driver and no
  // decode glitch ever reaches the port.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= '0;
    end else begin
      pins.o <= pin_o_next;
      pins.oe <= pin_oe_next;
    end
  end
endmodule : pwm_top
`default_nettype wire

// [testbench/pwm_top_sva.sv]
// Checker of the APB answer and pin behaviour of the PWM top.
`timescale 1ns/10ps
`default_nettype none
module pwm_top_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire pwm_pkg::pwm_apb_req_t apb_req,
  input wire pwm_pkg::pwm_apb_rsp_t apb_rsp,
  input wire logic [pwm_pkg::NUM_CH-1:0] gpio_out,
  input wire logic [pwm_pkg::NUM_CH-1:0] port_direction_in,
  input wire pwm_pkg::pwm_pins_t pins
);
  import pwm_pkg::*;
  logic [3:0] en_reg;
  logic [1:0] pair_reg;
  logic [3:0] drv;
  logic live_reg;
  logic setup;
  logic wr_en;
  logic wr_clk;
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr_en = apb_rsp.pready && apb_req.pwrite && apb_req.penable &&
    apb_req.paddr == {2'b00, IDX_EN, 2'b00};
  assign wr_clk = apb_rsp.pready && apb_req.pwrite && apb_req.penable &&
    apb_req.paddr == {2'b00, IDX_CLK, 2'b00};
  // A paired odd channel never drives its pin.
  assign drv = en_reg & ~{pair_reg[1], 1'b0, pair_reg[0], 1'b0};
  // Shadow of enables and pairing; pins lag them by one registered stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= 4'h0;
      pair_reg <= 2'b00;
      live_reg <= 1'b0;
    end else begin
      live_reg <= 1'b1;
      if (wr_en) begin
        en_reg <= apb_req.pwdata[3:0];
      end
      if (wr_clk) begin
        pair_reg <= {apb_req.pwdata[CLK_PAIR_UPPER_BIT],
                     apb_req.pwdata[CLK_PAIR_LOWER_BIT]};
      end
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (setup |=> apb_rsp.pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  a_err_no_data: assert property (apb_rsp.pready && apb_rsp.pslverr |->
    apb_rsp.prdata == 32'h0)
    else $error("error answer carries data");
  a_upper_bits_zero: assert property (apb_rsp.pready |->
    apb_rsp.prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_ctrl_no_err: assert property (setup &&
    apb_req.paddr inside {12'h100, 12'h104} |=> !apb_rsp.pslverr)
    else $error("control register refused");
  a_unmapped_err: assert property (setup && apb_req.paddr == 12'h180
    |=> apb_rsp.pready && apb_rsp.pslverr)
    else $error("unmapped access not refused");
  a_rdata_hold: assert property (!setup |=> $stable(apb_rsp.prdata))
    else $error("read data moved without setup");
  a_pin_drive: assert property (live_reg |-> pins.oe ==
    ($past(port_direction_in) | $past(drv)))
    else $error("pin enable wrong");
  a_pin_gpio: assert property (live_reg |-> ((pins.o ^ $past(gpio_out)) &
    ~$past(drv)) == 4'h0)
    else $error("idle pin not port value");
  cover property (wr_en);
  cover property (apb_rsp.pready && apb_rsp.pslverr);
  cover property ($rose(pins.o[0]) && en_reg[0]);
  cover property (pair_reg[1] && en_reg[2] && en_reg[3]);
endmodule : pwm_top_sva
bind pwm_top pwm_top_sva u_pwm_top_sva (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .gpio_out(gpio_out),
  .port_direction_in(port_direction_in), .pins(pins));
`default_nettype wire

// [testbench/pwm_top_test.sv]
// Self-checking bench of the PWM top over APB.
`timescale 1ns/10ps
`default_nettype none
module pwm_top_test;
  import pwm_pkg::*;
  logic pclk;
  logic presetn;
  pwm_apb_req_t apb_req;
  pwm_apb_rsp_t apb_rsp;
  logic [3:0] gpio_out;
  logic [3:0] dir;
  pwm_pins_t pins;
  int mismatches;
  int n_checks;
  logic [31:0] rdat;
  logic rerr;
  pwm_top u_pwm_top (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .gpio_out(gpio_out), .port_direction_in(dir),
    .pins(pins));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] idx,
    input logic [7:0] d);
    int i;
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, w, {2'b00, idx, 2'b00}, {24'h0, d}};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (apb_rsp.pready === 1'b1) break;
    end
    rdat = apb_rsp.prdata;
    rerr = apb_rsp.pslverr;
    apb_req <= '0;
    if (i == 16) begin
      mismatches++;
      test_done();
    end
  endtask : apb
  // The window is a multiple of every period used, so counts are exact.
  task automatic meas(input logic [7:0] c, input int rs, input int hi);
    int nh;
    int nr;
    logic p;
    nh = 0;
    nr = 0;
    repeat (20) @(posedge pclk);
    p = pins.o[c];
    repeat (96) begin
      @(posedge pclk);
      nh += int'(pins.o[c] === 1'b1);
      nr += int'(pins.o[c] === 1'b1 && p === 1'b0);
      p = pins.o[c];
    end
    chk("rising edges", rs, nr);
    chk("high cycles", hi, nh);
    $display("test on channel %0d done", c);
  endtask : meas
  task automatic run_case(input logic [7:0] c, input logic [7:0] clk,
    input logic [7:0] pol, input logic [7:0] al, input logic [7:0] du,
    input int rs, input int hi);
    apb(1'b1, IDX_EN, 8'h00);
    apb(1'b1, IDX_CLK, clk);
    apb(1'b1, IDX_POL, pol);
    apb(1'b1, IDX_ALIGN, al);
    apb(1'b1, IDX_PER0 + c, 8'h03);
    apb(1'b1, IDX_DUTY0 + c, du);
    apb(1'b1, IDX_CNT0 + c, 8'h00);
    apb(1'b1, IDX_EN, 8'h01 << c);
    apb(1'b0, IDX_POL, 8'h00);
    chk("polarity reg", {24'h0, pol}, rdat);
    meas(c, rs, hi);
  endtask : run_case
  initial begin
    presetn = 1'b0;
    apb_req = '0;
    gpio_out = 4'hA;
    dir = 4'h5;
    mismatches = 0;
    n_checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, IDX_CLK, 8'h00);
    chk("clock reg reset", 32'h0, rdat);
    apb(1'b0, IDX_PER0, 8'h00);
    chk("period reset", 32'hFF, rdat);
    apb(1'b0, 8'h60, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    $display("test reset values done");
    apb(1'b1, IDX_SCAL0, 8'h01);
    apb(1'b1, IDX_SCAL1, 8'h01);
    run_case(0, 8'h00, 8'h01, 8'h00, 8'h01, 24, 24);
    run_case(0, 8'h00, 8'h00, 8'h00, 8'h01, 24, 72);
    run_case(0, 8'h08, 8'h01, 8'h00, 8'h01, 12, 24);
    run_case(0, 8'h10, 8'h01, 8'h00, 8'h01, 6, 24);
    run_case(0, 8'h00, 8'h01, 8'h00, 8'h00, 0, 0);
    run_case(0, 8'h00, 8'h01, 8'h00, 8'h04, 0, 96);
    run_case(1, 8'h00, 8'h22, 8'h00, 8'h01, 6, 24);
    run_case(0, 8'h00, 8'h01, 8'h01, 8'h01, 16, 16);
    run_case(2, 8'h01, 8'h04, 8'h00, 8'h01, 12, 24);
    run_case(3, 8'h00, 8'h88, 8'h00, 8'h01, 6, 24);
    apb(1'b1, IDX_EN, 8'h00);
    apb(1'b1, IDX_CLK, 8'h40);
    apb(1'b1, IDX_POL, 8'h01);
    apb(1'b1, IDX_ALIGN, 8'h00);
    apb(1'b1, IDX_PER0, 8'h00);
    apb(1'b1, IDX_PER0 + 8'h01, 8'h03);
    apb(1'b1, IDX_DUTY0, 8'h00);
    apb(1'b1, IDX_DUTY0 + 8'h01, 8'h01);
    apb(1'b1, IDX_CNT0, 8'h00);
    apb(1'b1, IDX_EN, 8'h01);
    meas(0, 24, 24);
    apb(1'b0, IDX_CNT0 + 8'h01, 8'h00);
    chk("live count", 32'h1, {31'h0, rdat <= 32'h3});
    apb(1'b1, IDX_EN, 8'h00);
    apb(1'b1, IDX_CNT0, 8'h00);
    apb(1'b0, IDX_CNT0 + 8'h01, 8'h00);
    chk("cleared count", 32'h0, rdat);
    $display("test lower pairing done");
    apb(1'b1, IDX_CLK, 8'h38);
    apb(1'b1, IDX_POL, 8'h00);
    apb(1'b1, IDX_PER0, 8'h03);
    apb(1'b1, IDX_DUTY0, 8'hFF);
    apb(1'b1, IDX_CNT0, 8'h00);
    apb(1'b1, IDX_EN, 8'h01);
    apb(1'b1, IDX_DUTY0, 8'h00);
    repeat (4) @(posedge pclk);
    chk("old duty kept", 32'h0, {31'h0, pins.o[0]});
    apb(1'b0, IDX_DUTY0, 8'h00);
    chk("duty buffer", 32'h0, rdat);
    repeat (600) @(posedge pclk);
    chk("new duty at rollover", 32'h1, {31'h0, pins.o[0]});
    $display("test double buffering done");
    apb(1'b1, IDX_EN, 8'h00);
    apb(1'b1, IDX_CLK, 8'h80);
    apb(1'b1, IDX_POL, 8'h04);
    apb(1'b1, IDX_PER0 + 8'h02, 8'h00);
    apb(1'b1, IDX_PER0 + 8'h03, 8'h03);
    apb(1'b1, IDX_DUTY0 + 8'h02, 8'h00);
    apb(1'b1, IDX_DUTY0 + 8'h03, 8'h01);
    apb(1'b1, IDX_CNT0 + 8'h03, 8'h00);
    apb(1'b1, IDX_EN, 8'h0C);
    meas(2, 24, 24);
    gpio_out <= 4'h5;
    dir <= 4'h0;
    repeat (2) @(posedge pclk);
    chk("paired pin enables", 32'h4, {28'h0, pins.oe});
    chk("port pin values", 32'h1, {28'h0, pins.o & 4'hB});
    apb(1'b1, IDX_EN, 8'h00);
    repeat (2) @(posedge pclk);
    chk("idle pin enables", 32'h0, {28'h0, pins.oe});
    chk("idle pin values", 32'h5, {28'h0, pins.o});
    $display("test upper pairing and port pins done");
    test_done();
  end
endmodule : pwm_top_test
`default_nettype wire
